// ==== rtl/masp_pkg.sv ====
// Constants for the converter sequencer and block power control.
// Assumes a 50 MHz core clock and a 24-bit serial frame from the host.
`default_nettype none

package masp_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned CONV_TIME_NS     = 2000;
  localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RDY_PULSE_NS     = 1000;
  localparam int unsigned RDY_PULSE_CYCLES = RDY_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RST_NS      = 30000;
  localparam int unsigned SOFT_RST_CYCLES  = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned HDR_BITS   = 8;
  localparam int unsigned RW_POS     = 23;
  localparam int unsigned ADDR_MSB   = 22;
  localparam int unsigned ADDR_LSB   = 16;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_CHAN_ENABLE   = 7'h37;
  localparam logic [6:0] ADDR_INPUT_RANGE   = 7'h38;
  localparam logic [6:0] ADDR_BLOCK_POWER   = 7'h3B;
  localparam logic [6:0] ADDR_KEYED_RESET   = 7'h3E;
  localparam logic [6:0] ADDR_DEV_IDENTITY  = 7'h40;
  localparam logic [6:0] ADDR_CONV_CONFIG   = 7'h4A;

  // ---------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PWR_ADC_POS      = 14;
  localparam int unsigned PWR_REF_POS      = 13;
  localparam int unsigned PWR_OUT0_POS     = 12;
  localparam logic [15:0] PWR_MASK         = 16'h7E00;
  localparam logic [15:0] PWR_RESET        = 16'h0000;
  localparam logic [15:0] RESET_KEY        = 16'h6600;
  localparam logic [15:0] KEYED_RST_RESET  = 16'h0000;
  localparam logic [15:0] IDENTITY_VALUE   = 16'h0A5A;  // Arbitrary value
  localparam logic [15:0] EN_MASK          = 16'h6DE0;
  localparam logic [15:0] EN_RESET         = 16'h0000;
  localparam logic [31:0] EN_POS           = {4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB, 4'hD, 4'hE};
  localparam int unsigned RANGE_CH0_POS    = 15;
  localparam logic [15:0] RANGE_MASK       = 16'hFF00;
  localparam logic [15:0] RANGE_RESET      = 16'hFF00;
  localparam int unsigned CFG_MODE_POS     = 13;
  localparam int unsigned CFG_READY_POS    = 7;
  localparam int unsigned CFG_TRIG_POS     = 2;
  localparam logic        CFG_MODE_RESET   = 1'b1;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic {
    MASP_IDLE,
    MASP_CONV
  } masp_state_t;

endpackage : masp_pkg

`default_nettype wire

// ==== rtl/masp_core.sv ====
// Serial register slave, block power control and converter sequencer.
// Assumes the host drives a 24-bit mode-0 frame, far slower than the core clock.
//
// Summary of operation
// RULE1 - Power bit 14 powers the primary converter: 0 down, 1 active.
// RULE2 - Power bit 13 enables reference buffer, internal reference and drives reference pin.
// RULE3 - Power bits 12..9 power output converters 0..3; off means output high impedance.
// RULE4 - Writing 0x6600 to reset register 0x3E starts a full device reset.
// RULE5 - All serial transactions are ignored while the keyed reset runs.
// RULE6 - Host waits at least 30 us after keyed reset before next transaction.
// RULE7 - Identity register is fixed, read-only, and ignores writes.
// RULE8 - Eight inputs are multiplexed into one successive-approximation core.
// RULE9 - Range register holds one bit per channel: 0 reference, 1 twice reference.
// RULE10 - Writing 1 to the trigger bit triggers a conversion.
// RULE11 - New trigger aborts conversion and restarts from the first enabled channel.
// RULE12 - Config bit 13 selects continuous (1) or single-pass (0); resets to continuous.
// RULE13 - Single-pass converts each enabled channel once, then idles awaiting trigger.
// RULE14 - Continuous mode sweeps enabled channels in order, repeating forever.
// RULE15 - Trigger, mode change or channel register rewrite ends the current cycle.
// RULE16 - Host should not trigger in the same write that changes mode.
// RULE17 - Trigger plus mode change single to continuous stops and returns to idle.
// RULE18 - Host keeps serial clock quiet during conversion to reduce noise.
// RULE19 - Enabled channels are converted; disabled channels are skipped.
// RULE20 - Single-pass completion sets ready flag and drives data-available low.
// RULE21 - Trigger bit is a self-clearing strobe, one start per write, reads zero.
`default_nettype none

module masp_core (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Serial link
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdi,
  output var  logic       o_sdo,
  output var  logic       o_sdo_oe,
  // Power control
  output var  logic       o_adc_power,
  output var  logic       o_ref_buf_power,
  output var  logic       o_ref_internal_sel,
  output var  logic       o_ref_pin_oe,
  output var  logic [3:0] o_out_conv_power,
  output var  logic [3:0] o_out_conv_pin_oe,
  // Converter control
  output var  logic [2:0] o_mux_sel,
  output var  logic       o_range_2x,
  output var  logic       o_sample_start,
  output var  logic       o_converting,
  output var  logic       o_data_available_n,
  // Device reset
  output var  logic       o_soft_reset_busy
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] chan_bits(input logic [15:0] en);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = en[masp_pkg::EN_POS[4*i +: 4]];
    end
    return r;
  endfunction

  function automatic logic [3:0] next_chan(input logic [7:0] en, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Link input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sclk_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] sdi_sync_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      sdi_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], i_cs_n};
      sdi_sync_reg  <= {sdi_sync_reg[0], i_sdi};
    end
  end

  wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire cs_act    = ~cs_sync_reg[1];

  // ---------------------------------------------------------------
  // Keyed soft reset
  // ---------------------------------------------------------------
  logic [10:0] srst_cnt_reg;
  logic        srst_fire_reg;
  logic        wr_stb;
  logic [6:0]  wr_addr;
  logic [15:0] wr_data;

  wire srst_busy = srst_cnt_reg != 11'h000;
  wire rst_all   = i_rst | srst_fire_reg;
  wire key_hit   = wr_stb && (wr_addr == masp_pkg::ADDR_KEYED_RESET) && (wr_data == masp_pkg::RESET_KEY);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      srst_cnt_reg  <= 11'h000;
      srst_fire_reg <= 1'b0;
    end else begin
      srst_fire_reg <= key_hit;  // [RULE4]
      if (key_hit) begin
        srst_cnt_reg <= 11'(masp_pkg::SOFT_RST_CYCLES);
      end else if (srst_busy) begin
        srst_cnt_reg <= srst_cnt_reg - 11'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial slave
  // ---------------------------------------------------------------
  logic [23:0] rx_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] tx_reg;
  logic        blocked_reg;
  logic        sdo_reg;
  logic        sdo_oe_reg;
  logic [15:0] rdata;

  wire [6:0] hdr_addr = {rx_reg[5:0], sdi_sync_reg[1]};

  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      rx_reg      <= 24'h000000;
      bit_cnt_reg <= 5'h00;
      tx_reg      <= 16'h0000;
      blocked_reg <= 1'b0;
      sdo_reg     <= 1'b0;
      sdo_oe_reg  <= 1'b0;
    end else begin
      sdo_oe_reg <= cs_act;
      if (cs_fall) begin
        bit_cnt_reg <= 5'h00;
        blocked_reg <= srst_busy;  // [RULE5]
        sdo_reg     <= 1'b0;
      end else if (cs_act && !blocked_reg && !srst_busy) begin  // [RULE5]
        if (sclk_rise && bit_cnt_reg != 5'(masp_pkg::FRAME_BITS)) begin
          rx_reg      <= {rx_reg[22:0], sdi_sync_reg[1]};
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'(masp_pkg::HDR_BITS - 1)) begin
            tx_reg <= rdata;
          end
        end else if (sclk_fall && bit_cnt_reg >= 5'(masp_pkg::HDR_BITS)) begin
          sdo_reg <= tx_reg[15];
          tx_reg  <= {tx_reg[14:0], 1'b0};
        end
      end
    end
  end

  assign wr_stb  = cs_rise && !blocked_reg && !srst_busy && !rx_reg[masp_pkg::RW_POS]
                   && (bit_cnt_reg == 5'(masp_pkg::FRAME_BITS));
  assign wr_addr = rx_reg[masp_pkg::ADDR_MSB:masp_pkg::ADDR_LSB];
  assign wr_data = rx_reg[15:0];

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] power_reg;
  logic [15:0] keyed_rst_reg;
  logic [15:0] enable_reg;
  logic [15:0] range_reg;
  logic        mode_reg;
  logic        ready_reg;

  wire wr_power  = wr_stb && (wr_addr == masp_pkg::ADDR_BLOCK_POWER);
  wire wr_keyed  = wr_stb && (wr_addr == masp_pkg::ADDR_KEYED_RESET);
  wire wr_enable = wr_stb && (wr_addr == masp_pkg::ADDR_CHAN_ENABLE);
  wire wr_range  = wr_stb && (wr_addr == masp_pkg::ADDR_INPUT_RANGE);
  wire wr_cfg    = wr_stb && (wr_addr == masp_pkg::ADDR_CONV_CONFIG);
  wire trig      = wr_cfg && wr_data[masp_pkg::CFG_TRIG_POS];  // [RULE10] [RULE21]
  wire new_mode  = wr_data[masp_pkg::CFG_MODE_POS];
  wire mode_chg  = wr_cfg && (new_mode != mode_reg);

  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      power_reg     <= masp_pkg::PWR_RESET;
      keyed_rst_reg <= masp_pkg::KEYED_RST_RESET;
      enable_reg    <= masp_pkg::EN_RESET;
      range_reg     <= masp_pkg::RANGE_RESET;
      mode_reg      <= masp_pkg::CFG_MODE_RESET;  // [RULE12]
    end else begin
      if (wr_power) begin
        power_reg <= wr_data & masp_pkg::PWR_MASK;
      end
      if (wr_keyed) begin
        keyed_rst_reg <= wr_data;
      end
      if (wr_enable) begin
        enable_reg <= wr_data & masp_pkg::EN_MASK;
      end
      if (wr_range) begin
        range_reg <= wr_data & masp_pkg::RANGE_MASK;  // [RULE9]
      end
      if (wr_cfg) begin
        mode_reg <= new_mode;  // [RULE12]
      end
    end
  end

  // Identity is a constant; no write path reaches it [RULE7]
  always_comb begin
    rdata = 16'h0000;
    unique case (hdr_addr)
      masp_pkg::ADDR_BLOCK_POWER:  rdata = power_reg;
      masp_pkg::ADDR_KEYED_RESET:  rdata = keyed_rst_reg;
      masp_pkg::ADDR_DEV_IDENTITY: rdata = masp_pkg::IDENTITY_VALUE;  // [RULE7]
      masp_pkg::ADDR_CHAN_ENABLE:  rdata = enable_reg;
      masp_pkg::ADDR_INPUT_RANGE:  rdata = range_reg;
      masp_pkg::ADDR_CONV_CONFIG: begin
        rdata[masp_pkg::CFG_MODE_POS]  = mode_reg;
        rdata[masp_pkg::CFG_READY_POS] = ready_reg;
      end
      default:                     rdata = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Power outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      o_adc_power        <= 1'b0;
      o_ref_buf_power    <= 1'b0;
      o_ref_internal_sel <= 1'b0;
      o_ref_pin_oe       <= 1'b0;
      o_out_conv_power   <= 4'h0;
      o_out_conv_pin_oe  <= 4'h0;
    end else begin
      o_adc_power        <= power_reg[masp_pkg::PWR_ADC_POS];  // [RULE1]
      o_ref_buf_power    <= power_reg[masp_pkg::PWR_REF_POS];  // [RULE2]
      o_ref_internal_sel <= power_reg[masp_pkg::PWR_REF_POS];  // [RULE2]
      o_ref_pin_oe       <= power_reg[masp_pkg::PWR_REF_POS];  // [RULE2]
      for (int i = 0; i < 4; i++) begin
        o_out_conv_power[i]  <= power_reg[masp_pkg::PWR_OUT0_POS - i];  // [RULE3]
        o_out_conv_pin_oe[i] <= power_reg[masp_pkg::PWR_OUT0_POS - i];  // [RULE3]
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  masp_pkg::masp_state_t state_reg;
  masp_pkg::masp_state_t state_next;
  logic [2:0] ch_reg;
  logic [2:0] ch_next;
  logic [6:0] conv_cnt_reg;
  logic [5:0] rdy_cnt_reg;
  logic       start_next;
  logic       pass_done;

  wire [7:0] en_ch     = chan_bits(enable_reg);  // [RULE19]
  wire [3:0] first_ch  = next_chan(en_ch, 4'h0);
  wire [3:0] after_ch  = next_chan(en_ch, {1'b0, ch_reg} + 4'h1);
  wire       conv_end  = (state_reg == masp_pkg::MASP_CONV)
                         && (conv_cnt_reg == 7'(masp_pkg::CONV_CYCLES - 1));
  wire       chan_wr   = wr_enable | wr_range;
  wire       to_auto   = mode_chg && new_mode;

  always_comb begin
    state_next = state_reg;
    ch_next    = ch_reg;
    start_next = 1'b0;
    pass_done  = 1'b0;
    if (trig && !to_auto && o_adc_power && !first_ch[3]) begin  // [RULE11]
      state_next = masp_pkg::MASP_CONV;
      ch_next    = first_ch[2:0];
      start_next = 1'b1;
    end else if (trig || mode_chg || chan_wr || !o_adc_power) begin  // [RULE15] [RULE17]
      state_next = masp_pkg::MASP_IDLE;
    end else if (conv_end) begin
      if (!after_ch[3]) begin  // [RULE19]
        ch_next    = after_ch[2:0];
        start_next = 1'b1;
      end else begin
        pass_done = 1'b1;
        if (mode_reg) begin  // [RULE14]
          ch_next    = first_ch[2:0];
          start_next = 1'b1;
        end else begin
          state_next = masp_pkg::MASP_IDLE;  // [RULE13]
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      state_reg    <= masp_pkg::MASP_IDLE;
      ch_reg       <= 3'h0;
      conv_cnt_reg <= 7'h00;
    end else begin
      state_reg    <= state_next;
      ch_reg       <= ch_next;
      conv_cnt_reg <= start_next ? 7'h00 : conv_cnt_reg + 7'h01;
    end
  end

  // Ready flag: a trigger wins over a pass ending in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      ready_reg   <= 1'b0;
      rdy_cnt_reg <= 6'h00;
    end else begin
      if (pass_done && !mode_reg) begin
        ready_reg <= 1'b1;  // [RULE20]
      end else if (trig) begin
        ready_reg <= 1'b0;
      end
      if (pass_done && mode_reg) begin
        rdy_cnt_reg <= 6'(masp_pkg::RDY_PULSE_CYCLES);
      end else if (rdy_cnt_reg != 6'h00) begin
        rdy_cnt_reg <= rdy_cnt_reg - 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Converter outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      o_mux_sel          <= 3'h0;
      o_range_2x         <= 1'b0;
      o_sample_start     <= 1'b0;
      o_converting       <= 1'b0;
      o_data_available_n <= 1'b1;
    end else begin
      o_mux_sel          <= ch_next;  // [RULE8]
      o_range_2x         <= range_reg[masp_pkg::RANGE_CH0_POS - ch_next];  // [RULE9]
      o_sample_start     <= start_next;
      o_converting       <= state_next == masp_pkg::MASP_CONV;
      o_data_available_n <= !((pass_done && !mode_reg) || (ready_reg && !trig)
                              || (pass_done && mode_reg) || (rdy_cnt_reg > 6'h01));  // [RULE20]
    end
  end

  // ---------------------------------------------------------------
  // Link and reset status outputs
  // ---------------------------------------------------------------
  logic srst_busy_reg;

  assign o_sdo             = sdo_reg;
  assign o_sdo_oe          = sdo_oe_reg;
  assign o_soft_reset_busy = srst_busy_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      srst_busy_reg <= 1'b0;
    end else begin
      srst_busy_reg <= srst_busy || key_hit;
    end
  end

endmodule : masp_core

`default_nettype wire

// ==== test/masp_host.sv ====
// Host model that drives the four-wire serial link.
// Assumes the core finds the link edges with its own clock.
`default_nettype none
module masp_host (
  // Serial link
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_sdi,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // --------------------------------------------
  // One 24-bit frame, MSB first
  // --------------------------------------------
  task automatic xfer(input logic [23:0] f, output logic [15:0] rd);
    rd = 16'h0000;
    #7 o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_sdi = f[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
      if (i < 16) rd = {rd[14:0], i_sdo};
    end
    #80 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;  // Released line shows no stale bit
    #240;            // Clock stands still between frames
  endtask

  // Quiet time after the keyed reset
  task automatic hold_off;
    #30000;
  endtask
endmodule // masp_host
`default_nettype wire

// ==== test/masp_core_properties.sv ====
// Concurrent checks on the sequencer and the power pins.
// Assumes a bind into masp_core and a synchronous active-high reset.
`default_nettype none
module masp_core_properties (
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  // Watched outputs
  input wire logic       o_adc_power,
  input wire logic       o_ref_buf_power,
  input wire logic       o_ref_internal_sel,
  input wire logic       o_ref_pin_oe,
  input wire logic [3:0] o_out_conv_power,
  input wire logic [3:0] o_out_conv_pin_oe,
  input wire logic [2:0] o_mux_sel,
  input wire logic       o_sample_start,
  input wire logic       o_converting,
  input wire logic       o_soft_reset_busy
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // --------------------------------------------
  // Busy length counter
  // --------------------------------------------
  logic [12:0] busy_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_soft_reset_busy) busy_cnt_reg <= 13'h0000;
    else busy_cnt_reg <= busy_cnt_reg + 13'h0001;
  end

  sequence s_busy_held;
    o_soft_reset_busy ##1 o_soft_reset_busy;
  endsequence

  // --------------------------------------------
  // Assertions
  // --------------------------------------------
  ref_tie_a: assert property (o_ref_internal_sel == o_ref_buf_power && o_ref_pin_oe == o_ref_buf_power)
    else $error("reference controls disagree");
  out_hiz_a: assert property (o_out_conv_pin_oe == o_out_conv_power)
    else $error("output enable differs from power");
  start_pulse_a: assert property (o_sample_start |=> !o_sample_start)
    else $error("sample start longer than one cycle");
  start_power_a: assert property (o_sample_start |-> o_adc_power && o_converting)
    else $error("sample start without converter power");
  first_start_a: assert property ($rose(o_converting) |-> o_sample_start)
    else $error("conversion began without start pulse");
  mux_hold_a: assert property (o_converting && $changed(o_mux_sel) |-> o_sample_start)
    else $error("channel moved inside a conversion");
  busy_len_a: assert property ($fell(o_soft_reset_busy) && !$past(i_rst) |->
    busy_cnt_reg >= masp_pkg::SOFT_RST_CYCLES) else $error("reset blackout too short");
  busy_dflt_a: assert property (s_busy_held |->
    !o_adc_power && !o_ref_buf_power && o_out_conv_power == 4'h0 && !o_converting)
    else $error("state not at defaults during reset");
endmodule // masp_core_properties

bind masp_core masp_core_properties chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .o_adc_power(o_adc_power),
  .o_ref_buf_power(o_ref_buf_power), .o_ref_internal_sel(o_ref_internal_sel),
  .o_ref_pin_oe(o_ref_pin_oe), .o_out_conv_power(o_out_conv_power),
  .o_out_conv_pin_oe(o_out_conv_pin_oe), .o_mux_sel(o_mux_sel),
  .o_sample_start(o_sample_start), .o_converting(o_converting),
  .o_soft_reset_busy(o_soft_reset_busy));
`default_nettype wire

// ==== test/masp_core_tb.sv ====
// Testbench for the sequencer, power pins and keyed reset.
// Assumes the host model drives the link at a 160 ns bit period.
`default_nettype none
module masp_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------
  // Signals
  // --------------------------------------------
  logic        clk;
  logic        i_rst = 1'b1;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, adc_pw, ref_buf, ref_sel, ref_oe;
  logic        rng, start, conv, dav_n, busy;
  logic [2:0]  mux;
  logic [3:0]  ocp, ocoe;
  logic [3:0]  rq[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [15:0] pv [8] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'hFFFF, 16'h0000};
  logic [3:0]  ex [3] = '{4'h1, 4'hC, 4'h7};
  wire logic [15:0] pw_seen = {adc_pw, ref_buf, ref_sel, ref_oe, ocp, ocoe, 4'h0};

  masp_core dut (
    .i_core_clk(clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_adc_power(adc_pw), .o_ref_buf_power(ref_buf),
    .o_ref_internal_sel(ref_sel), .o_ref_pin_oe(ref_oe), .o_out_conv_power(ocp),
    .o_out_conv_pin_oe(ocoe), .o_mux_sel(mux), .o_range_2x(rng), .o_sample_start(start),
    .o_converting(conv), .o_data_available_n(dav_n), .o_soft_reset_busy(busy));
  masp_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Start log and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) rq.push_back({rng, mux});
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  // --------------------------------------------
  // Tasks
  // --------------------------------------------
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    host.xfer({1'b0, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
    logic [15:0] r;
    host.xfer({1'b1, a, 16'h0000}, r);
    check($sformatf("register %h", a), e, r & m);
  endtask
  task automatic wait_ch1;
    for (int k = 0; k < 400 && !(start === 1'b1 && mux === 3'h1); k++) @(negedge clk);
  endtask
  function automatic logic [15:0] pexp(input logic [15:0] v);
    logic [3:0] o;
    o = {v[9], v[10], v[11], v[12]};
    return {v[14], {3{v[13]}}, o, o, 4'h0};
  endfunction
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------
  // Main sequence
  // --------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("data available", 16'h0001, dav_n);
    check("power pins", 16'h0000, pw_seen);
    check("sdo enable", 16'h0000, sdo_oe);
    rd(7'h40, masp_pkg::IDENTITY_VALUE, 16'hFFFF);
    rd(7'h3B, 16'h0000, 16'hFFFF);
    rd(7'h3E, 16'h0000, 16'hFFFF);
    rd(7'h38, 16'hFF00, 16'hFFFF);
    rd(7'h4A, 16'h2000, 16'h2084);
    rd(7'h7F, 16'h0000, 16'hFFFF);
    wr(7'h40, 16'hFFFF);
    rd(7'h40, masp_pkg::IDENTITY_VALUE, 16'hFFFF);
    foreach (pv[k]) begin
      wr(7'h3B, pv[k]);
      check("power pins", pexp(pv[k]), pw_seen);
      rd(7'h3B, pv[k] & 16'h7E00, 16'hFFFF);
    end
    // Single pass over channels 1, 4 and 7, channel 4 at double range
    wr(7'h3B, 16'h4000);
    wr(7'h37, 16'h2120);
    wr(7'h38, 16'h0800);
    wr(7'h4A, 16'h0000);
    rq.delete();
    wr(7'h4A, 16'h0004);
    for (int k = 0; k < 1000 && dav_n !== 1'b0; k++) @(negedge clk);
    repeat (200) @(negedge clk);
    check("start count", 16'h0003, 16'(rq.size()));
    foreach (rq[k]) check("channel", ex[k % 3], rq[k]);
    check("data available", 16'h0000, dav_n);
    rd(7'h4A, 16'h0080, 16'h2084);
    // Continuous sweep, then restart in mid sweep
    wr(7'h4A, 16'h2000);
    check("converting", 16'h0000, conv);
    rq.delete();
    wr(7'h4A, 16'h2004);
    for (int k = 0; k < 1000 && rq.size() < 6; k++) @(negedge clk);
    for (int k = 0; k < 6; k++) check("channel", ex[k % 3], rq[k]);
    wait_ch1();
    repeat (50) @(negedge clk);
    rq.delete();
    wr(7'h4A, 16'h2004);
    check("restart count", 16'h0003, 16'(rq.size()));
    check("restart channel", 16'h0001, rq[2]);
    wr(7'h4A, 16'h0000);
    repeat (150) @(negedge clk);
    check("converting", 16'h0000, conv);
    wr(7'h4A, 16'h2004);
    wr(7'h4A, 16'h2004);
    check("converting", 16'h0001, conv);
    wr(7'h37, 16'h2120);
    check("converting", 16'h0000, conv);
    wr(7'h4A, 16'h0000);
    rq.delete();
    wr(7'h4A, 16'h2004);
    repeat (150) @(negedge clk);
    check("converting", 16'h0000, conv);
    check("start count", 16'h0000, 16'(rq.size()));
    // Keyed reset and blackout
    wr(7'h3B, 16'h7E00);
    wr(7'h3E, masp_pkg::RESET_KEY);
    check("reset busy", 16'h0001, busy);
    check("power pins", 16'h0000, pw_seen);
    wr(7'h3B, 16'h4000);
    check("power pins", 16'h0000, pw_seen);
    rd(7'h40, 16'h0000, 16'hFFFF);
    host.hold_off();
    check("reset busy", 16'h0000, busy);
    rd(7'h3B, 16'h0000, 16'hFFFF);
    rd(7'h4A, 16'h2000, 16'h2000);
    complete_run();
  end
endmodule // masp_core_tb
`default_nettype wire
